// [rre_pkg.sv]
// constants and types for the return and rotate execution block
package rre_pkg;
   localparam int PC_W = 13;
   localparam int DATA_W = 8;
   localparam logic [PC_W-1:0] PC_RST = 13'h0000;
   localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
   localparam int MSB = 7;
   localparam int RET_CYCLES = 2;
   typedef enum logic [3:0] {
      RRE_OP_NONE,
      RRE_OP_SUB_EXIT,
      RRE_OP_SUB_EXIT_LIT,
      RRE_OP_INT_EXIT,
      RRE_OP_ROT_L,
      RRE_OP_ROT_L_W,
      RRE_OP_ROT_LC,
      RRE_OP_ROT_LC_W,
      RRE_OP_ROT_R,
      RRE_OP_ROT_R_W,
      RRE_OP_ROT_RC,
      RRE_OP_ROT_RC_W
   } rre_op_t;
   typedef enum {
      RRE_IDLE,
      RRE_EXIT2
   } rre_state_t;
endpackage

// [rre_exec.sv]
// return and rotate execution unit: pc, working register, carry, irq enable
`timescale 1ns/1ps
`default_nettype none
module rre_exec (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic op_valid,
   input wire rre_pkg::rre_op_t op_code,
   input wire logic [7:0] op_literal,
   input wire logic [7:0] mem_rdata,
   input wire logic [12:0] stack_top,
   output logic op_ready,
   output logic stack_pop,
   output logic [12:0] pc,
   output logic [7:0] acc,
   output logic carry,
   output logic global_irq_enable,
   output logic [7:0] mem_wdata,
   output logic mem_we
);
   rre_pkg::rre_state_t state_reg, state_next;
   // op_reg keeps the exit being finished so the dead cycle can be checked against it
   rre_pkg::rre_op_t op_reg, op_next;
   logic [12:0] pc_reg, pc_next;
   logic [7:0] acc_reg, acc_next;
   logic carry_reg, carry_next;
   logic gie_reg, gie_next;
   logic [7:0] wdata_reg, wdata_next;
   logic we_reg, we_next;
   logic [7:0] rot_res;
   logic rot_c;
   logic rot_to_mem, rot_to_acc, rot_sets_c;

   // the rotate result is formed every cycle; the state logic decides whether it lands
   // via-carry forms read the carry held before this op, never the one it produces
   always_comb begin
      rot_res = mem_rdata;
      rot_c = carry_reg;
      rot_to_mem = 1'b0;
      rot_to_acc = 1'b0;
      rot_sets_c = 1'b0;
      unique case (op_code)
         rre_pkg::RRE_OP_ROT_L: begin
            rot_res = {mem_rdata[6:0], mem_rdata[rre_pkg::MSB]};
            rot_to_mem = 1'b1;
         end
         rre_pkg::RRE_OP_ROT_L_W: begin
            rot_res = {mem_rdata[6:0], mem_rdata[rre_pkg::MSB]};
            rot_to_acc = 1'b1;
         end
         rre_pkg::RRE_OP_ROT_LC: begin
            rot_res = {mem_rdata[6:0], carry_reg};
            rot_c = mem_rdata[rre_pkg::MSB];
            rot_to_mem = 1'b1;
            rot_sets_c = 1'b1;
         end
         rre_pkg::RRE_OP_ROT_LC_W: begin
            rot_res = {mem_rdata[6:0], carry_reg};
            rot_c = mem_rdata[rre_pkg::MSB];
            rot_to_acc = 1'b1;
            rot_sets_c = 1'b1;
         end
         rre_pkg::RRE_OP_ROT_R: begin
            rot_res = {mem_rdata[0], mem_rdata[7:1]};
            rot_to_mem = 1'b1;
         end
         rre_pkg::RRE_OP_ROT_R_W: begin
            rot_res = {mem_rdata[0], mem_rdata[7:1]};
            rot_to_acc = 1'b1;
         end
         rre_pkg::RRE_OP_ROT_RC: begin
            rot_res = {carry_reg, mem_rdata[7:1]};
            rot_c = mem_rdata[0];
            rot_to_mem = 1'b1;
            rot_sets_c = 1'b1;
         end
         rre_pkg::RRE_OP_ROT_RC_W: begin
            // through-carry right into the working register, memory untouched
            rot_res = {carry_reg, mem_rdata[7:1]};
            rot_c = mem_rdata[0];
            rot_to_acc = 1'b1;
            rot_sets_c = 1'b1;
         end
         default: begin
         end
      endcase
   end

   assign op_ready = (state_reg == rre_pkg::RRE_IDLE);
   // pop in the first cycle only; the second cycle is the refill slot
   assign stack_pop = op_ready && op_valid && (op_code == rre_pkg::RRE_OP_SUB_EXIT
      || op_code == rre_pkg::RRE_OP_SUB_EXIT_LIT || op_code == rre_pkg::RRE_OP_INT_EXIT);

   always_comb begin
      state_next = state_reg;
      op_next = op_reg;
      pc_next = pc_reg;
      acc_next = acc_reg;
      carry_next = carry_reg;
      gie_next = gie_reg;
      wdata_next = wdata_reg;
      we_next = 1'b0;
      unique case (state_reg)
         rre_pkg::RRE_IDLE: begin
            if (stack_pop) begin
               pc_next = stack_top;
               op_next = op_code;
               state_next = rre_pkg::RRE_EXIT2;
               if (op_code == rre_pkg::RRE_OP_SUB_EXIT_LIT) begin
                  acc_next = op_literal;
               end
               if (op_code == rre_pkg::RRE_OP_INT_EXIT) begin
                  gie_next = 1'b1;
               end
            end else if (op_valid) begin
               if (rot_to_mem) begin
                  wdata_next = rot_res;
                  we_next = 1'b1;
               end
               if (rot_to_acc) begin
                  acc_next = rot_res;
               end
               if (rot_sets_c) begin
                  carry_next = rot_c;
               end
            end
         end
         rre_pkg::RRE_EXIT2: begin
            // an op offered here is dropped; the caller must offer it again
            op_next = rre_pkg::RRE_OP_NONE;
            state_next = rre_pkg::RRE_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_reg <= rre_pkg::RRE_IDLE;
         op_reg <= rre_pkg::RRE_OP_NONE;
         pc_reg <= rre_pkg::PC_RST;
         acc_reg <= rre_pkg::ACC_RST;
         carry_reg <= 1'b0;
         gie_reg <= 1'b0;
         wdata_reg <= 8'h00;
         we_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         pc_reg <= pc_next;
         acc_reg <= acc_next;
         carry_reg <= carry_next;
         gie_reg <= gie_next;
         wdata_reg <= wdata_next;
         we_reg <= we_next;
      end
   end

   assign pc = pc_reg;
   assign acc = acc_reg;
   assign carry = carry_reg;
   assign global_irq_enable = gie_reg;
   assign mem_wdata = wdata_reg;
   assign mem_we = we_reg;

   // exits: pc reload, two-cycle occupancy, flags untouched
   AST_EXIT_PC: assert property (@(posedge core_clk) disable iff (!rst_b)
      stack_pop |=> pc == $past(stack_top)) else $error("pc not reloaded");
   AST_EXIT_TWO: assert property (@(posedge core_clk) disable iff (!rst_b)
      stack_pop |=> !op_ready ##1 op_ready) else $error("exit not two cycles");
   AST_EXIT_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_b)
      stack_pop |=> $stable(carry)) else $error("exit touched carry");
   AST_POP_ONCE: assert property (@(posedge core_clk) disable iff (!rst_b)
      stack_pop |=> !stack_pop) else $error("stack popped twice for one exit");
   // the second cycle belongs to the exit that started it
   AST_EXIT_OP: assert property (@(posedge core_clk) disable iff (!rst_b)
      !op_ready |-> op_reg inside {rre_pkg::RRE_OP_SUB_EXIT, rre_pkg::RRE_OP_SUB_EXIT_LIT,
      rre_pkg::RRE_OP_INT_EXIT}) else $error("dead cycle without an exit");
   AST_DEAD_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_b)
      !op_ready |=> !mem_we && $stable(acc) && $stable(carry) && $stable(pc))
      else $error("op taken in the dead cycle");
   AST_EXIT_LIT: assert property (@(posedge core_clk) disable iff (!rst_b)
      stack_pop && op_code == rre_pkg::RRE_OP_SUB_EXIT_LIT |=> acc == $past(op_literal))
      else $error("literal not loaded");
   AST_INT_EXIT: assert property (@(posedge core_clk) disable iff (!rst_b)
      stack_pop && op_code == rre_pkg::RRE_OP_INT_EXIT |=> global_irq_enable)
      else $error("irq enable not set");
   // rotates: result one cycle after the op is taken
   AST_RLC: assert property (@(posedge core_clk) disable iff (!rst_b)
      op_ready && op_valid && op_code == rre_pkg::RRE_OP_ROT_LC
      |=> mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(carry)}
      && carry == $past(mem_rdata[7])) else $error("rlc wrong");
   AST_RLCW: assert property (@(posedge core_clk) disable iff (!rst_b)
      op_ready && op_valid && op_code == rre_pkg::RRE_OP_ROT_LC_W
      |=> !mem_we && acc == {$past(mem_rdata[6:0]), $past(carry)}
      && carry == $past(mem_rdata[7])) else $error("rlc to acc wrong");
   AST_RR: assert property (@(posedge core_clk) disable iff (!rst_b)
      op_ready && op_valid && op_code == rre_pkg::RRE_OP_ROT_R
      |=> mem_we && mem_wdata == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}
      && $stable(carry)) else $error("rr wrong");
   AST_RRW: assert property (@(posedge core_clk) disable iff (!rst_b)
      op_ready && op_valid && op_code == rre_pkg::RRE_OP_ROT_R_W
      |=> !mem_we && acc == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
      else $error("rr to acc wrong");
   AST_RRC: assert property (@(posedge core_clk) disable iff (!rst_b)
      op_ready && op_valid && op_code == rre_pkg::RRE_OP_ROT_RC
      |=> mem_we && mem_wdata == {$past(carry), $past(mem_rdata[7:1])}
      && carry == $past(mem_rdata[0])) else $error("rrc wrong");
   AST_RL: assert property (@(posedge core_clk) disable iff (!rst_b)
      op_ready && op_valid && op_code == rre_pkg::RRE_OP_ROT_L
      |=> mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}
      && $stable(carry)) else $error("rl wrong");
   AST_RLW: assert property (@(posedge core_clk) disable iff (!rst_b)
      op_ready && op_valid && op_code == rre_pkg::RRE_OP_ROT_L_W
      |=> !mem_we && $stable(carry)
      && acc == {$past(mem_rdata[6:0]), $past(mem_rdata[7])})
      else $error("rl to acc wrong");

   COV_INT_EXIT: cover property (@(posedge core_clk) disable iff (!rst_b)
      stack_pop && op_code == rre_pkg::RRE_OP_INT_EXIT);
   COV_LIT_EXIT: cover property (@(posedge core_clk) disable iff (!rst_b)
      stack_pop && op_code == rre_pkg::RRE_OP_SUB_EXIT_LIT);
   COV_DEAD_OFFER: cover property (@(posedge core_clk) disable iff (!rst_b)
      !op_ready && op_valid);
   COV_RLC_WB: cover property (@(posedge core_clk) disable iff (!rst_b)
      op_ready && op_valid && op_code == rre_pkg::RRE_OP_ROT_LC);
   COV_RRC_ACC: cover property (@(posedge core_clk) disable iff (!rst_b)
      op_ready && op_valid && op_code == rre_pkg::RRE_OP_ROT_RC_W);
endmodule
`default_nettype wire

// [rre_exec_test.sv]
// self-checking testbench for the return and rotate execution unit
`timescale 1ns/1ps
`default_nettype none
module rre_exec_test;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic op_valid = 1'b0;
   rre_pkg::rre_op_t op_code = rre_pkg::RRE_OP_NONE;
   logic [7:0] op_literal = 8'h00;
   logic [7:0] mem_rdata = 8'h00;
   logic [12:0] stack_top = 13'h0000;
   logic op_ready, stack_pop, carry, global_irq_enable, mem_we;
   logic [12:0] pc;
   logic [7:0] acc, mem_wdata;
   int n_mismatch = 0;
   int comparisons = 0;
   logic c_exp = 1'b0;
   logic [7:0] acc_exp = 8'h00;
   logic [12:0] pc_exp = 13'h0000;
   logic gie_exp = 1'b0;

   rre_exec u_dut (.core_clk(core_clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
      .op_literal(op_literal), .mem_rdata(mem_rdata), .stack_top(stack_top),
      .op_ready(op_ready), .stack_pop(stack_pop), .pc(pc), .acc(acc), .carry(carry),
      .global_irq_enable(global_irq_enable), .mem_wdata(mem_wdata), .mem_we(mem_we));

   always #50 core_clk = ~core_clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic test_reset();
      check({pc, acc, carry, global_irq_enable, mem_we, op_ready}, {13'h0, 8'h0, 4'b0001});
      check(mem_wdata, 8'h00);
   endtask

   // the op held in the dead cycle must be ignored, so memory must not be written
   task automatic test_exit(input rre_pkg::rre_op_t op, input logic [12:0] st,
                            input logic [7:0] lit);
      @(posedge core_clk);
      op_valid <= 1'b1;
      op_code <= op;
      stack_top <= st;
      op_literal <= lit;
      #1 check(stack_pop, 1'b1);
      if (op == rre_pkg::RRE_OP_SUB_EXIT_LIT) acc_exp = lit;
      if (op == rre_pkg::RRE_OP_INT_EXIT) gie_exp = 1'b1;
      @(posedge core_clk);
      op_code <= rre_pkg::RRE_OP_ROT_R;
      mem_rdata <= 8'h01;
      stack_top <= ~st;
      #1 check({pc, op_ready, stack_pop}, {st, 2'b00});
      check(acc, acc_exp);
      check({global_irq_enable, carry}, {gie_exp, c_exp});
      @(posedge core_clk);
      op_valid <= 1'b0;
      #1 check({mem_we, op_ready, pc}, {2'b01, st});
      pc_exp = st;
   endtask

   task automatic test_rotates();
      rre_pkg::rre_op_t ops[8];
      logic [7:0] din[8];
      logic [7:0] res;
      logic to_acc;
      ops = '{rre_pkg::RRE_OP_ROT_LC, rre_pkg::RRE_OP_ROT_L, rre_pkg::RRE_OP_ROT_L_W,
              rre_pkg::RRE_OP_ROT_LC_W, rre_pkg::RRE_OP_ROT_R, rre_pkg::RRE_OP_ROT_R_W,
              rre_pkg::RRE_OP_ROT_RC_W, rre_pkg::RRE_OP_ROT_RC};
      din = '{8'h80, 8'h01, 8'hC3, 8'h7F, 8'h01, 8'h96, 8'h81, 8'h00};
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         op_valid <= 1'b1;
         op_code <= ops[i];
         mem_rdata <= din[i];
         case (ops[i])
            rre_pkg::RRE_OP_ROT_L, rre_pkg::RRE_OP_ROT_L_W: res = {din[i][6:0], din[i][7]};
            rre_pkg::RRE_OP_ROT_R, rre_pkg::RRE_OP_ROT_R_W: res = {din[i][0], din[i][7:1]};
            rre_pkg::RRE_OP_ROT_LC, rre_pkg::RRE_OP_ROT_LC_W: begin
               res = {din[i][6:0], c_exp};
               c_exp = din[i][7];
            end
            default: begin
               res = {c_exp, din[i][7:1]};
               c_exp = din[i][0];
            end
         endcase
         to_acc = ops[i] inside {rre_pkg::RRE_OP_ROT_L_W, rre_pkg::RRE_OP_ROT_LC_W,
                                 rre_pkg::RRE_OP_ROT_R_W, rre_pkg::RRE_OP_ROT_RC_W};
         if (to_acc) acc_exp = res;
         #1 check(stack_pop, 1'b0);
         @(posedge core_clk);
         op_valid <= 1'b0;
         #1 check({mem_we, carry}, {~to_acc, c_exp});
         check(acc, acc_exp);
         if (!to_acc) check(mem_wdata, res);
         check({pc, global_irq_enable}, {pc_exp, gie_exp});
         @(posedge core_clk);
         #1 check(mem_we, 1'b0);
      end
   endtask

   // the idle code must leave carry, acc, pc and irq enable as they were and write no memory
   task automatic test_none();
      @(posedge core_clk);
      op_valid <= 1'b1;
      op_code <= rre_pkg::RRE_OP_NONE;
      mem_rdata <= 8'hFF;
      @(posedge core_clk);
      op_valid <= 1'b0;
      #1 check({mem_we, carry, acc, pc, global_irq_enable},
               {1'b0, c_exp, acc_exp, pc_exp, gie_exp});
   endtask

   initial begin
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      #1 test_reset();
      test_rotates();
      test_none();
      test_exit(rre_pkg::RRE_OP_SUB_EXIT, 13'h1ABC, 8'h3C);
      test_exit(rre_pkg::RRE_OP_SUB_EXIT_LIT, 13'h0F0F, 8'hA5);
      test_exit(rre_pkg::RRE_OP_INT_EXIT, 13'h1234, 8'h5A);
      test_rotates();
      give_verdict();
   end

   // the run needs well under 100 cycles, so 2000 only trips on a hang
   initial begin
      #(2000 * 100);
      n_mismatch++;
      give_verdict();
   end
endmodule
`default_nettype wire
